//--- logic/otp_spi_pkg.sv
// Constants, register map and state encoding for the OTP serial access block.
// Assumes a 50 MHz system clock and a word-aligned Avalon-MM register window.
package otp_spi_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ   = 50;
    localparam int T_LOCK_US = 1300;                  // POR plus PLL lock wait
    localparam int LOCK_CYC  = T_LOCK_US * CLK_MHZ;   // Cycles of that wait

    // ------------------------------------------------------------------
    // Memory and packet geometry
    // ------------------------------------------------------------------
    localparam int BANKS      = 3;
    localparam int WORDS      = 4096;
    localparam int WBITS      = 12;
    localparam int SIG_BITS   = 32;
    localparam int WR_BITS    = 64;
    localparam int RD_BITS    = 24;
    localparam int RSP_BITS   = 40;
    localparam int TUP_BITS   = 19;
    localparam int TUP_POS [3] = '{5, 24, 43};        // First bit of each tuple
    localparam int LAST_POS   = 62;
    localparam int BANK_POS   = 8;
    localparam int RWORD_POS  = 10;
    localparam logic [1:0] OP_READ  = 2'h0;           // Written {bit0, bit1}
    localparam logic [1:0] OP_RSVD  = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_EXIT  = 2'h3;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_IRQ_STAT = 4'h8;
    localparam logic [3:0]  REG_IRQ_MASK = 4'hc;
    localparam logic [31:0] CTRL_RST     = 32'h00000001;
    localparam logic [31:0] MASK_RST     = 32'h00000000;
    localparam int IRQ_W     = 6;
    localparam int EV_MATCH  = 0;
    localparam int EV_WPKT   = 1;
    localparam int EV_LAST   = 2;
    localparam int EV_RDONE  = 3;
    localparam int EV_PERR   = 4;
    localparam int EV_REFUSE = 5;

    typedef enum logic [6:0] {
        ST_BOOT   = 7'b0000001,
        ST_COPY   = 7'b0000010,
        ST_LOCKED = 7'b0000100,
        ST_SIG    = 7'b0001000,
        ST_CMD    = 7'b0010000,
        ST_PROG   = 7'b0100000,
        ST_RESP   = 7'b1000000
    } state_t;
endpackage

//--- logic/otp_spi_slave_access.sv
// Serial slave front end of the three one-time-programmable banks.
// Assumes an SPI mode 0 master on the pins and an Avalon-MM master on the bus.
//
// Summary of operation
// - Three banks of 4096 words, 32 bits each, reached only via this slave.
// - A programmed image is copied to configuration memory after every reset.
// - With an image present, host, flash, write and read access are disabled.
// - A matching signature raises the match output for the host.
// - Write packet is eight bytes with three address and nibble tuples.
// - Bit 6 of byte eight marks the final write packet.
// - Reserved bits of byte one ignored; byte eight bit 7 is parity.
// - Byte one opcode: 00 read, 01 reserved, 10 write, 11 exit.
// - Writes start only with overdrive and program mode inputs active.
// - A three-byte read command returns a five-byte response.
// - Address bits 18:17 pick the bank, 16:10 and 4:0 the word.
// - Read parity is the exclusive-or of all preceding command bits.
// - Commands arrive on serial input; read data leave on serial output.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module otp_spi_slave_access #(
    parameter logic [31:0] SIG_WORD = 32'h5a3c96e1,           // Arbitrary value
    parameter int          LOCK_CYC = otp_spi_pkg::LOCK_CYC
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_power_enable_pin,
    input  wire logic        i_image_present,
    input  wire logic        i_overdrive,
    input  wire logic        i_program_mode,
    input  wire logic        i_spi_sclk,
    input  wire logic        i_spi_ss_n,
    input  wire logic        i_spi_mosi,
    output logic             o_spi_miso,
    output logic             o_spi_miso_oe_n,
    output logic             o_sig_match,
    output logic             o_host_load_en,
    output logic             o_flash_load_en,
    output logic             o_image_present,
    output logic             o_cfg_valid,
    output logic [13:0]      o_cfg_addr,
    output logic [31:0]      o_cfg_data,
    output logic             o_cfg_done,
    output logic             o_prog_valid,
    output logic [1:0]       o_prog_bank,
    output logic [11:0]      o_prog_word,
    output logic [2:0]       o_prog_nib,
    output logic [3:0]       o_prog_data,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_irq
);
    localparam int TW  = $clog2(LOCK_CYC + 1);
    localparam int NS  = 7;
    localparam int CPW = 14;
    localparam int IRQ_W = otp_spi_pkg::IRQ_W;

    otp_spi_pkg::state_t st_q, st_d;
    logic [NS-1:0]       s1_q, s2_q;
    logic                sclk_q3, got_q, drop_q, match_q, lock_q, strap_q, written_q;
    logic [6:0]          cnt_q;
    logic [5:0]          oidx_q;
    logic [1:0]          pcnt_q;
    logic [63:0]         pk_q;
    logic [39:0]         rsp_q;
    logic [TW-1:0]       tmr_q;
    logic [CPW-1:0]      cp_q;
    logic                miso_q, ack_q, ctrl_en_q;
    logic [IRQ_W-1:0]    irq_q, mask_q;
    logic [31:0]         mem [otp_spi_pkg::BANKS][otp_spi_pkg::WORDS];

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    wire [NS-1:0] raw = {i_power_enable_pin, i_image_present, i_overdrive,
                         i_program_mode, i_spi_sclk, i_spi_ss_n, i_spi_mosi};

    // Two stages per pin; sclk gets a third for edge finding
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q    <= '0;
            s2_q    <= '0;
            sclk_q3 <= 1'b0;
        end else begin
            s1_q    <= raw;
            s2_q    <= s1_q;
            sclk_q3 <= s2_q[2];
        end
    end

    wire pwr_s  = s2_q[6];
    wire img_s  = s2_q[5];
    wire od_s   = s2_q[4];
    wire pm_s   = s2_q[3];
    wire sclk_s = s2_q[2];
    wire ss_s   = s2_q[1];
    wire mosi_s = s2_q[0];

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    // Mode 0: sample on rising sclk, shift out on falling sclk
    wire rise    = sclk_s & ~sclk_q3;
    wire fall    = ~sclk_s & sclk_q3;
    wire is_sig  = (st_q == otp_spi_pkg::ST_SIG);
    wire is_cmd  = (st_q == otp_spi_pkg::ST_CMD);
    wire is_prog = (st_q == otp_spi_pkg::ST_PROG);
    wire is_resp = (st_q == otp_spi_pkg::ST_RESP);
    wire is_boot = (st_q == otp_spi_pkg::ST_BOOT);
    wire is_copy = (st_q == otp_spi_pkg::ST_COPY);
    wire in_rx   = ~ss_s & rise & (is_sig | is_cmd) & ~drop_q;
    wire [1:0] op = {pk_q[0], pk_q[1]};

    wire sig_done = got_q & is_sig & (cnt_q == 7'(otp_spi_pkg::SIG_BITS));
    wire sig_hit  = sig_done & ctrl_en_q & (pk_q[31:0] == SIG_WORD);
    wire byte1    = got_q & is_cmd & (cnt_q == 7'h08);
    wire op_exit  = byte1 & (op == otp_spi_pkg::OP_EXIT);
    wire op_rsvd  = byte1 & (op == otp_spi_pkg::OP_RSVD);
    wire rd_done  = got_q & is_cmd & (op == otp_spi_pkg::OP_READ)
                  & (cnt_q == 7'(otp_spi_pkg::RD_BITS));
    wire wr_done  = got_q & is_cmd & (op == otp_spi_pkg::OP_WRITE)
                  & (cnt_q == 7'(otp_spi_pkg::WR_BITS));
    // Byte one bits 2..4 enter only the parity checks; P closes even parity
    wire wpar_ok  = ~^pk_q;
    wire rpar_ok  = ~^pk_q[otp_spi_pkg::RD_BITS-1:0];
    wire wr_ok    = wr_done & wpar_ok & od_s & pm_s;
    wire prog_end = is_prog & (pcnt_q == 2'h2);
    wire wr_last  = prog_end & pk_q[otp_spi_pkg::LAST_POS];
    wire rsp_end  = is_resp & (ss_s | (rise & (oidx_q == 6'(otp_spi_pkg::RSP_BITS))));
    wire tmr_done = (tmr_q == TW'(LOCK_CYC - 1));
    wire boot_go  = is_boot & pwr_s & strap_q & tmr_done;
    wire cp_last  = (cp_q == CPW'(otp_spi_pkg::BANKS * otp_spi_pkg::WORDS - 1));

    // Read command address: bank in bits 18:17, word from 16:10 and 4:0
    logic [otp_spi_pkg::WBITS-1:0] rc_word;
    wire  [1:0] rc_bank = {pk_q[otp_spi_pkg::BANK_POS], pk_q[otp_spi_pkg::BANK_POS+1]};
    for (genvar i = 0; i < otp_spi_pkg::WBITS; i++) begin : g_rword
        assign rc_word[otp_spi_pkg::WBITS-1-i] = pk_q[otp_spi_pkg::RWORD_POS+i];
    end
    wire bank_ok = (rc_bank < 2'(otp_spi_pkg::BANKS));

    // One read port shared by the boot copy and host reads
    wire [1:0]  rd_bank = is_copy ? cp_q[13:12] : rc_bank;
    wire [11:0] rd_word = is_copy ? cp_q[11:0] : rc_word;
    wire [31:0] mem_rd  = (rd_bank < 2'(otp_spi_pkg::BANKS)) ? mem[rd_bank][rd_word] : 32'h0;
    wire [31:0] rd_val  = (bank_ok & rpar_ok) ? mem_rd : 32'h0;

    // Write tuple k of the packet goes to bank k
    function automatic logic [18:0] tuple(input logic [63:0] p, input int b);
        logic [18:0] r;
        r = '0;
        for (int i = 0; i < otp_spi_pkg::TUP_BITS; i++) begin
            r[18-i] = p[b+i];
        end
        return r;
    endfunction

    wire [18:0] tup    = tuple(pk_q, otp_spi_pkg::TUP_POS[pcnt_q]);
    wire [11:0] t_word = {tup[18:13], tup[12:7]};
    wire [2:0]  t_nib  = tup[6:4];
    wire [31:0] t_mask = {28'h0, tup[3:0]} << {t_nib, 2'h0};

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            otp_spi_pkg::ST_BOOT: begin
                if (boot_go) begin
                    st_d = lock_q ? otp_spi_pkg::ST_COPY : otp_spi_pkg::ST_SIG;
                end
            end
            otp_spi_pkg::ST_COPY: begin
                if (cp_last) begin
                    st_d = otp_spi_pkg::ST_LOCKED;
                end
            end
            otp_spi_pkg::ST_LOCKED: st_d = otp_spi_pkg::ST_LOCKED;
            otp_spi_pkg::ST_SIG: begin
                if (sig_hit) begin
                    st_d = otp_spi_pkg::ST_CMD;
                end
            end
            otp_spi_pkg::ST_CMD: begin
                if (op_exit) begin
                    st_d = otp_spi_pkg::ST_SIG;
                end else if (rd_done) begin
                    st_d = otp_spi_pkg::ST_RESP;
                end else if (wr_ok) begin
                    st_d = otp_spi_pkg::ST_PROG;
                end
            end
            otp_spi_pkg::ST_PROG: begin
                if (prog_end) begin
                    st_d = otp_spi_pkg::ST_CMD;
                end
            end
            otp_spi_pkg::ST_RESP: begin
                if (rsp_end) begin
                    st_d = otp_spi_pkg::ST_CMD;
                end
            end
            default: st_d = otp_spi_pkg::ST_BOOT;
        endcase
        if (!pwr_s) begin
            st_d = otp_spi_pkg::ST_BOOT;
        end
    end

    // Bit counter restarts on deselect, state change or a complete unit
    wire       cnt_clr = ss_s | (st_d != st_q) | wr_done | sig_done;
    wire [6:0] cnt_d   = cnt_clr ? 7'h00 : (in_rx ? cnt_q + 7'h01 : cnt_q);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q   <= otp_spi_pkg::ST_BOOT;
            cnt_q  <= 7'h00;
            got_q  <= 1'b0;
            drop_q <= 1'b0;
            pk_q   <= 64'h0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            got_q  <= in_rx;
            drop_q <= ~ss_s & (drop_q | op_rsvd);  // Reserved opcode: ignore to deselect
            if (in_rx) begin
                pk_q[cnt_q[5:0]] <= mosi_s;
            end
        end
    end

    // Strap is caught once after reset; a restart folds in a fresh image
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_q   <= 1'b0;
            lock_q    <= 1'b0;
            written_q <= 1'b0;
            match_q   <= 1'b0;
            tmr_q     <= '0;
        end else begin
            strap_q   <= strap_q | (is_boot & pwr_s);
            if (is_boot & pwr_s & ~strap_q) begin
                lock_q <= img_s;
            end else if (!pwr_s) begin
                lock_q <= lock_q | written_q;
            end
            written_q <= written_q | wr_last;
            match_q   <= pwr_s & ~op_exit & (match_q | sig_hit);
            tmr_q     <= (is_boot & pwr_s & ~tmr_done) ? tmr_q + TW'(1) : (is_boot ? tmr_q : '0);
        end
    end

    // ------------------------------------------------------------------
    // Boot copy, programming and read response
    // ------------------------------------------------------------------
    // Blank fuses read as zero; programming can only set bits
    initial begin
        for (int b = 0; b < otp_spi_pkg::BANKS; b++) begin
            for (int w = 0; w < otp_spi_pkg::WORDS; w++) begin
                mem[b][w] = 32'h0;
            end
        end
    end

    // Plain always: the blank-fuse initial block writes this array as well
    always @(posedge i_clk_sys) begin
        if (is_prog) begin
            mem[pcnt_q][t_word] <= mem[pcnt_q][t_word] | t_mask;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cp_q         <= '0;
            o_cfg_valid  <= 1'b0;
            o_cfg_addr   <= 14'h0;
            o_cfg_data   <= 32'h0;
            pcnt_q       <= 2'h0;
            o_prog_valid <= 1'b0;
            o_prog_bank  <= 2'h0;
            o_prog_word  <= 12'h0;
            o_prog_nib   <= 3'h0;
            o_prog_data  <= 4'h0;
        end else begin
            cp_q         <= is_copy ? cp_q + CPW'(1) : '0;
            o_cfg_valid  <= is_copy;
            o_cfg_addr   <= cp_q;
            o_cfg_data   <= mem_rd;
            pcnt_q       <= is_prog ? pcnt_q + 2'h1 : 2'h0;
            o_prog_valid <= is_prog;
            o_prog_bank  <= pcnt_q;
            o_prog_word  <= t_word;
            o_prog_nib   <= t_nib;
            o_prog_data  <= tup[3:0];
        end
    end

    // Response: status byte, then data low byte first, each bit 0 first
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rsp_q  <= 40'h0;
            oidx_q <= 6'h00;
            miso_q <= 1'b0;
        end else begin
            if (rd_done) begin
                rsp_q  <= {rd_val, 6'h00, bank_ok, rpar_ok};
                oidx_q <= 6'h00;
            end else if (is_resp & fall & ~ss_s & (oidx_q < 6'(otp_spi_pkg::RSP_BITS))) begin
                miso_q <= rsp_q[oidx_q];
                oidx_q <= oidx_q + 6'h01;
            end else if (!is_resp) begin
                miso_q <= 1'b0;
            end
        end
    end

    assign o_spi_miso      = miso_q;
    assign o_spi_miso_oe_n = ss_s | ~is_resp;
    assign o_sig_match     = match_q;
    assign o_host_load_en  = ~lock_q;
    assign o_flash_load_en = ~lock_q;
    assign o_image_present = lock_q;
    assign o_cfg_done      = (st_q == otp_spi_pkg::ST_LOCKED);

    // ------------------------------------------------------------------
    // Register bus and interrupts
    // ------------------------------------------------------------------
    // One wait cycle per access keeps read data registered
    wire        acc     = i_avs_read | i_avs_write;
    wire        wr_fire = i_avs_write & ack_q;
    wire        rd_take = i_avs_read & ~ack_q;
    wire [31:0] wmask   = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                           {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    wire [31:0] wd      = i_avs_writedata & wmask;
    wire hit_ctrl = (i_avs_address == otp_spi_pkg::REG_CTRL);
    wire hit_stat = (i_avs_address == otp_spi_pkg::REG_STATUS);
    wire hit_irq  = (i_avs_address == otp_spi_pkg::REG_IRQ_STAT);
    wire hit_mask = (i_avs_address == otp_spi_pkg::REG_IRQ_MASK);
    wire [31:0] status = {19'h0, st_q, 3'h0, written_q, lock_q, match_q};
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_en_q} :
                         hit_stat ? status :
                         hit_irq  ? {26'h0, irq_q} :
                         hit_mask ? {26'h0, mask_q} : 32'h0;

    // Hardware events win over a same-cycle write-one-to-clear
    wire [IRQ_W-1:0] ev  = {op_rsvd | (wr_done & wpar_ok & ~(od_s & pm_s)),
                            (wr_done & ~wpar_ok) | (rd_done & ~rpar_ok),
                            rd_done, wr_last, prog_end, sig_hit};
    wire [IRQ_W-1:0] clr = (wr_fire & hit_irq) ? wd[IRQ_W-1:0] : '0;

    assign o_avs_waitrequest = acc & ~ack_q;
    assign o_irq             = |(irq_q & mask_q);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_q          <= 1'b0;
            o_avs_readdata <= 32'h0;
            ctrl_en_q      <= otp_spi_pkg::CTRL_RST[0];
            mask_q         <= otp_spi_pkg::MASK_RST[IRQ_W-1:0];
            irq_q          <= '0;
        end else begin
            ack_q <= acc & ~ack_q;
            if (rd_take) begin
                o_avs_readdata <= rd_mux;
            end
            if (wr_fire & hit_ctrl & i_avs_byteenable[0]) begin
                ctrl_en_q <= wd[0];
            end
            if (wr_fire & hit_mask & i_avs_byteenable[0]) begin
                mask_q <= wd[IRQ_W-1:0];
            end
            irq_q <= (irq_q & ~clr) | ev;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_sig_match_set: assert property (sig_hit |=> o_sig_match && is_cmd)
        else $error("signature hit did not raise match");
    a_lock_quiet: assert property (lock_q |-> !o_host_load_en && !o_sig_match)
        else $error("locked device still open to host");
    a_copy_valid: assert property (is_copy |=> o_cfg_valid && o_cfg_addr == $past(cp_q))
        else $error("boot copy word missing");
    a_prog_burst: assert property ($rose(is_prog) |-> !o_prog_valid ##1 o_prog_valid[*3] ##1 !o_prog_valid)
        else $error("program burst not three tuples");
    a_prog_gate: assert property ($rose(is_prog) |-> $past(od_s && pm_s && wpar_ok))
        else $error("programming without mode inputs or parity");
    a_last_flag: assert property ($rose(written_q) |-> $past(is_prog && pk_q[62]))
        else $error("image flag set without last packet");
    a_exit_op: assert property (op_exit |=> !o_sig_match && is_sig)
        else $error("exit opcode did not leave command mode");
    a_read_resp: assert property (rd_done |=> is_resp && oidx_q == 6'h00)
        else $error("read command not answered");
    a_rd_parity: assert property (rd_done && !rpar_ok |=> rsp_q[39:0] == 40'h2 || rsp_q == 40'h0)
        else $error("bad parity still returned data");
    a_rd_bank: assert property (rd_done && rc_bank == 2'h3 |=> rsp_q[39:8] == 32'h0 && !rsp_q[1])
        else $error("invalid bank returned data");
    a_irq_sticky: assert property (ev[0] |=> irq_q[0])
        else $error("event lost against clear");

    c_match: cover property (sig_hit);
    c_prog_last: cover property (wr_last);
    c_read: cover property (rsp_end && !ss_s);
    c_copy_done: cover property (is_copy && cp_last);
endmodule // otp_spi_slave_access

//--- sim/spi_host_model.sv
// Behavioural SPI mode 0 host that sends and takes frames bit 0 first.
// Assumes the system clock paces it: four cycles per half of a 160 ns bit.
`timescale 1ns/10ps
module spi_host_model (
    input  wire logic i_clk,
    input  wire logic i_miso,
    output logic      o_sclk,
    output logic      o_ss_n,
    output logic      o_mosi
);
    initial begin
        o_sclk = 1'b0;
        o_ss_n = 1'b1;
        o_mosi = 1'b0;
    end
    // Clock stands low between frames; mosi flips when it carries nothing
    task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        o_ss_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            o_mosi <= tx[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            rx[i] = i_miso;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_ss_n <= 1'b1;
        o_mosi <= ~tx[n-1];
    endtask
endmodule // spi_host_model

//--- sim/otp_spi_slave_access_tb.sv
// Self-checking bench: register bus calls plus serial host traffic.
// Assumes a 50 MHz clock and a lock wait shortened to 20 cycles.
`timescale 1ns/10ps
module otp_spi_slave_access_tb;
    logic        clk = 1'b0, rst_n = 1'b0, power_enable_pin = 1'b1, img = 1'b0, od = 1'b0, pm = 1'b0;
    logic        sclk, ss_n, mosi, miso, match, irq, hle, lock, done, wreq, oe_n, fle;
    // Released line shows the inverse, so a sample outside the response is caught
    wire         miso_ln = oe_n ? ~miso : miso;
    logic        rd = 1'b0, wr = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rv;
    logic [63:0] rx;
    int          miscompares = 0, checked = 0, cyc = 0;
    always #10 clk = ~clk;
    spi_host_model i_host (.i_clk(clk), .i_miso(miso_ln), .o_sclk(sclk), .o_ss_n(ss_n),
        .o_mosi(mosi));
    otp_spi_slave_access #(.LOCK_CYC(20)) i_dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_power_enable_pin(power_enable_pin), .i_image_present(img),
        .i_overdrive(od), .i_program_mode(pm), .i_spi_sclk(sclk), .i_spi_ss_n(ss_n),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n), .o_sig_match(match),
        .o_host_load_en(hle), .o_flash_load_en(fle), .o_image_present(lock), .o_cfg_valid(),
        .o_cfg_addr(), .o_cfg_data(), .o_cfg_done(done), .o_prog_valid(), .o_prog_bank(),
        .o_prog_word(), .o_prog_nib(), .o_prog_data(), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq));
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Read command: bank in address bits 18:17, parity makes the xor zero
    function automatic logic [63:0] rcmd(input logic [1:0] bank, input logic bad);
        logic [23:0] c;
        c = {14'h0, bank[0], bank[1], 8'h0};
        c[23] = ^c[22:0] ^ bad;
        return {40'h0, c};
    endfunction
    // Write packet with reserved bits set to show they are ignored
    function automatic logic [63:0] wpkt(input logic [3:0] nib);
        logic [63:0] p;
        p = 64'h1d;
        p[23:20] = {nib[0], nib[1], nib[2], nib[3]};
        p[62] = 1'b1;
        p[63] = ^p[62:0];
        return p;
    endfunction
    task automatic stop_test;
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, otp_spi_pkg::REG_CTRL, 0);
        chk("ctrl", otp_spi_pkg::CTRL_RST, rv);
        bus(0, 4'h6, 0);
        chk("unmapped", 0, rv);
        bus(1, otp_spi_pkg::REG_IRQ_MASK, 32'h3f);
        repeat (40) @(posedge clk);
        i_host.xfer({32'h0, 32'h5a3c96e1}, 32, rx);
        chk("match", 1, match);
        chk("irq", 1, irq);
        bus(1, otp_spi_pkg::REG_IRQ_STAT, 32'h3f);
        repeat (3) @(posedge clk);
        chk("irq clear", 0, irq);
        repeat (4000) @(posedge clk);
        i_host.xfer(wpkt(4'hf), 64, rx);
        repeat (900) @(posedge clk);
        bus(0, otp_spi_pkg::REG_IRQ_STAT, 0);
        chk("refused", 32'h20, rv);
        bus(1, otp_spi_pkg::REG_IRQ_STAT, 32'h3f);
        i_host.xfer(64'h2, 64, rx);
        bus(0, otp_spi_pkg::REG_IRQ_STAT, 0);
        chk("reserved", 32'h20, rv);
        bus(1, otp_spi_pkg::REG_IRQ_STAT, 32'h3f);
        od <= 1'b1;
        pm <= 1'b1;
        repeat (506) @(posedge clk);
        i_host.xfer(wpkt(4'ha), 64, rx);
        repeat (506) @(posedge clk);
        bus(0, otp_spi_pkg::REG_IRQ_STAT, 0);
        chk("written", 32'h6, rv);
        for (int b = 0; b < 5; b++) begin
            i_host.xfer(rcmd(b[1:0], b == 4), 64, rx);
            chk("resp", {(b == 0) ? 32'ha : 32'h0, (b == 3) ? 8'h01 : (b == 4) ? 8'h02 : 8'h03},
                rx[63:24]);
            repeat (506) @(posedge clk);
        end
        i_host.xfer(64'h3, 24, rx);
        chk("exit", 0, match);
        img <= 1'b1;
        power_enable_pin <= 1'b0;
        repeat (8) @(posedge clk);
        power_enable_pin <= 1'b1;
        for (int k = 0; k < 13000 && done !== 1'b1; k++) @(posedge clk);
        chk("copied", 1, done);
        chk("locked", 3'b100, {lock, hle, fle});
        i_host.xfer({32'h0, 32'h5a3c96e1}, 32, rx);
        chk("no match", 0, match);
        stop_test();
    end
endmodule // otp_spi_slave_access_tb
